// *** core_regs_pkg.sv ***
// Shared types and constants for the core register set
package core_regs_pkg;

   // ==========================================
   // Widths
   localparam int NIBBLE_W = 4;
   localparam int PAIR_W = 8;
   localparam int PAGE_OFS_W = 3;
   localparam int PC_W = 14;
   localparam int DP_W = 10;
   localparam int STACK_DEPTH = 8;
   localparam int PTR_W = 3;

   // ==========================================
   // Reset values
   localparam logic [PTR_W-1:0] PTR_RESET = 3'h7;
   localparam logic [NIBBLE_W-1:0] ACC_RESET = 4'h0;
   localparam logic [NIBBLE_W-1:0] AUX_RESET = 4'h0;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic SKIP_RESET = 1'b0;

   // ==========================================
   // Operations issued by the sequencer
   typedef enum logic [4:0] {
      OP_NOP,
      OP_LOAD_ACC,
      OP_LOAD_AUX,
      OP_XCH_AUX,
      OP_ADD_IMM,
      OP_ADD_MEM,
      OP_ADD_MEM_CARRY,
      OP_AND_MEM,
      OP_OR_MEM,
      OP_CMP_MEM,
      OP_BIT_SET,
      OP_BIT_CLR,
      OP_BIT_TEST,
      OP_ROTATE_RIGHT,
      OP_SET_CARRY,
      OP_RESET_CARRY,
      OP_PAIR_FROM_AB,
      OP_PAIR_TO_AB,
      OP_LOAD_PAGE_OFS,
      OP_POINTER_TO_ACC,
      OP_CALL,
      OP_TABLE_FETCH,
      OP_RETURN,
      OP_INT_ENTRY,
      OP_INT_RETURN,
      OP_SKIP_SET,
      OP_SKIP_CLEAR
   } op_t;

   typedef struct packed {
      op_t op;
      logic [NIBBLE_W-1:0] operand;
      logic [1:0] bit_sel;
      logic [PC_W-1:0] pc;
      logic [DP_W-1:0] dp;
   } cmd_t;

   typedef struct packed {
      logic [DP_W-1:0] dp;
      logic carry;
      logic skip;
      logic [NIBBLE_W-1:0] acc;
      logic [NIBBLE_W-1:0] aux;
   } context_t;

   typedef struct packed {
      logic [NIBBLE_W-1:0] acc;
      logic [NIBBLE_W-1:0] aux;
      logic carry;
      logic skip;
      logic [PAIR_W-1:0] pair;
      logic [PAGE_OFS_W-1:0] page_ofs;
      logic [PTR_W-1:0] nesting_pointer;
      logic [6:0] table_addr;
   } view_t;

endpackage : core_regs_pkg

// *** return_stack.sv ***
// Eight-entry return-address stack with wrapping nesting pointer
`timescale 1ns/1ps
module return_stack #(
   parameter int DEPTH = core_regs_pkg::STACK_DEPTH,
   parameter int ADDR_W = core_regs_pkg::PC_W
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic push,
   input wire logic pop,
   input wire logic [ADDR_W-1:0] push_addr,
   output logic [ADDR_W-1:0] top_addr,
   output logic [core_regs_pkg::PTR_W-1:0] nesting_pointer
);
   import core_regs_pkg::*;

   logic [ADDR_W-1:0] entry_reg [DEPTH];
   logic [ADDR_W-1:0] entry_next [DEPTH];
   logic [PTR_W-1:0] ptr_reg;
   logic [PTR_W-1:0] ptr_next;

   // ==========================================
   // Next state
   always_comb begin
      entry_next = entry_reg;
      ptr_next = ptr_reg;
      if (push) begin
         // Overflow silently overwrites the oldest entry
         ptr_next = ptr_reg + 3'h1; // RULE_15
         entry_next[ptr_next] = push_addr; // RULE_12
      end else if (pop) begin
         ptr_next = ptr_reg - 3'h1; // RULE_24
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ptr_reg <= PTR_RESET; // RULE_22
      end else if (ce) begin
         ptr_reg <= ptr_next; // RULE_16
      end
   end

   // Entries have no reset; contents are only meaningful once pushed
   always_ff @(posedge core_clk) begin
      if (ce) begin
         entry_reg <= entry_next; // RULE_13
      end
   end

   assign top_addr = entry_reg[ptr_reg]; // RULE_24
   assign nesting_pointer = ptr_reg;

endmodule : return_stack

// *** cpu_core_register_set.sv ***
// Programmer-visible register set of the 4-bit core
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - ALU: 4-bit add, compare, AND, OR, bit ops
// RULE_02 - Accumulator is 4-bit operand and result holder
// RULE_03 - Add with carry sets carry on overflow
// RULE_04 - Plain adds leave carry unchanged
// RULE_05 - Rotate right moves bit 0 into carry
// RULE_06 - Set and reset carry force 1 and 0
// RULE_07 - Auxiliary nibble: temp storage, upper half pair
// RULE_08 - Pair loads from and to aux:acc
// RULE_09 - Software initialises pair register after reset
// RULE_10 - Page offset with acc forms 7-bit address
// RULE_11 - Software loads page offset after reset
// RULE_12 - Interrupt, call, table fetch push PC
// RULE_13 - Stack holds eight identical entries
// RULE_14 - Software keeps combined nesting within eight
// RULE_15 - Ninth push overwrites silently, no error
// RULE_16 - 3-bit pointer tracks pushes and pops
// RULE_17 - Transfer copies nesting pointer to accumulator
// RULE_18 - Interrupt entry saves DP, carry, skip, acc, aux
// RULE_19 - Only interrupt entry writes context save
// RULE_20 - Skip flag decides skipping of next instruction
// RULE_21 - Skip flag saved on interrupt entry
// RULE_22 - Pointer reads 7 after reset, wraps
// RULE_23 - Interrupt return restores context and pops PC
// RULE_24 - Return pops entry then decrements pointer
module cpu_core_register_set (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire core_regs_pkg::cmd_t cmd,
   input wire logic [core_regs_pkg::NIBBLE_W-1:0] mem_data,
   output core_regs_pkg::view_t view,
   output logic [core_regs_pkg::DP_W-1:0] restored_dp,
   output logic restored_dp_valid,
   output logic [core_regs_pkg::PC_W-1:0] return_pc,
   output logic return_valid,
   output logic skip_next
);
   import core_regs_pkg::*;

   // ==========================================
   // Functions
   function automatic logic [NIBBLE_W:0] add_nibble(input logic [NIBBLE_W-1:0] a,
                                                   input logic [NIBBLE_W-1:0] b,
                                                   input logic cin);
      add_nibble = {1'b0, a} + {1'b0, b} + {4'h0, cin}; // RULE_01
   endfunction : add_nibble

   function automatic logic [NIBBLE_W-1:0] bit_mask(input logic [1:0] sel);
      bit_mask = 4'h1 << sel;
   endfunction : bit_mask

   // ==========================================
   // State
   logic [NIBBLE_W-1:0] acc_reg, acc_next;
   logic [NIBBLE_W-1:0] aux_reg, aux_next;
   logic carry_reg, carry_next;
   logic skip_reg, skip_next_state;
   logic [PAIR_W-1:0] pair_reg, pair_next;
   logic [PAGE_OFS_W-1:0] page_ofs_reg, page_ofs_next;
   context_t ctx_reg, ctx_next;
   logic [DP_W-1:0] rdp_reg, rdp_next;
   logic rdp_valid_reg, rdp_valid_next;
   logic [PC_W-1:0] rpc_reg, rpc_next;
   logic rpc_valid_reg, rpc_valid_next;

   logic [NIBBLE_W:0] sum;
   logic push;
   logic pop;
   logic [PC_W-1:0] stack_top;
   logic [PTR_W-1:0] nesting_pointer;

   // ==========================================
   // Return stack
   assign push = (cmd.op == OP_CALL) || (cmd.op == OP_TABLE_FETCH) || (cmd.op == OP_INT_ENTRY); // RULE_12
   assign pop = (cmd.op == OP_RETURN) || (cmd.op == OP_INT_RETURN); // RULE_24

   return_stack #(
      .DEPTH(STACK_DEPTH),
      .ADDR_W(PC_W)
   ) u_stack (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .push(push),
      .pop(pop),
      .push_addr(cmd.pc),
      .top_addr(stack_top),
      .nesting_pointer(nesting_pointer)
   );

   // ==========================================
   // Datapath next state
   always_comb begin
      acc_next = acc_reg;
      aux_next = aux_reg;
      carry_next = carry_reg;
      skip_next_state = skip_reg;
      sum = add_nibble(acc_reg, (cmd.op == OP_ADD_IMM) ? cmd.operand : mem_data,
                       (cmd.op == OP_ADD_MEM_CARRY) ? carry_reg : 1'b0);
      // A skip is consumed by the next instruction other than OP_NOP
      if (cmd.op != OP_NOP) begin
         skip_next_state = 1'b0;
      end
      unique case (cmd.op)
         OP_NOP: begin
         end
         OP_LOAD_ACC: begin
            acc_next = cmd.operand; // RULE_02
         end
         OP_LOAD_AUX: begin
            aux_next = acc_reg; // RULE_07
         end
         OP_XCH_AUX: begin
            acc_next = aux_reg; // RULE_02
            aux_next = acc_reg;
         end
         OP_ADD_IMM, OP_ADD_MEM: begin
            acc_next = sum[NIBBLE_W-1:0]; // RULE_04
         end
         OP_ADD_MEM_CARRY: begin
            acc_next = sum[NIBBLE_W-1:0];
            carry_next = sum[NIBBLE_W]; // RULE_03
         end
         OP_AND_MEM: begin
            acc_next = acc_reg & mem_data; // RULE_01
         end
         OP_OR_MEM: begin
            acc_next = acc_reg | mem_data; // RULE_01
         end
         OP_CMP_MEM: begin
            skip_next_state = (acc_reg == mem_data); // RULE_20
         end
         OP_BIT_SET: begin
            acc_next = acc_reg | bit_mask(cmd.bit_sel); // RULE_01
         end
         OP_BIT_CLR: begin
            acc_next = acc_reg & ~bit_mask(cmd.bit_sel);
         end
         OP_BIT_TEST: begin
            skip_next_state = |(acc_reg & bit_mask(cmd.bit_sel)); // RULE_20
         end
         OP_ROTATE_RIGHT: begin
            acc_next = {carry_reg, acc_reg[NIBBLE_W-1:1]};
            carry_next = acc_reg[0]; // RULE_05
         end
         OP_SET_CARRY: begin
            carry_next = 1'b1; // RULE_06
         end
         OP_RESET_CARRY: begin
            carry_next = 1'b0; // RULE_06
         end
         OP_PAIR_TO_AB: begin
            aux_next = pair_reg[PAIR_W-1:NIBBLE_W]; // RULE_08
            acc_next = pair_reg[NIBBLE_W-1:0];
         end
         OP_POINTER_TO_ACC: begin
            acc_next = {1'b0, nesting_pointer}; // RULE_17
         end
         OP_PAIR_FROM_AB, OP_LOAD_PAGE_OFS, OP_CALL, OP_TABLE_FETCH, OP_RETURN: begin
            // Their state lives in the pair, context and return blocks
         end
         OP_INT_ENTRY: begin
            skip_next_state = 1'b0;
         end
         OP_INT_RETURN: begin
            acc_next = ctx_reg.acc; // RULE_23
            aux_next = ctx_reg.aux;
            carry_next = ctx_reg.carry;
            skip_next_state = ctx_reg.skip;
         end
         OP_SKIP_SET: begin
            skip_next_state = 1'b1; // RULE_20
         end
         OP_SKIP_CLEAR: begin
            skip_next_state = 1'b0;
         end
         default: begin
         end
      endcase
   end

   // ==========================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         acc_reg <= ACC_RESET;
         aux_reg <= AUX_RESET;
         carry_reg <= CARRY_RESET;
         skip_reg <= SKIP_RESET;
      end else if (ce) begin
         acc_reg <= acc_next;
         aux_reg <= aux_next;
         carry_reg <= carry_next;
         skip_reg <= skip_next_state;
      end
   end

   // ==========================================
   // Pair and page offset next state
   always_comb begin
      pair_next = pair_reg;
      page_ofs_next = page_ofs_reg;
      if (cmd.op == OP_PAIR_FROM_AB) begin
         pair_next = {aux_reg, acc_reg}; // RULE_08
      end
      if (cmd.op == OP_LOAD_PAGE_OFS) begin
         page_ofs_next = acc_reg[PAGE_OFS_W-1:0]; // RULE_10
      end
   end

   // Pair and page offset stay undefined after reset on purpose
   always_ff @(posedge core_clk) begin
      if (ce) begin
         pair_reg <= pair_next; // RULE_09
         page_ofs_reg <= page_ofs_next; // RULE_11
      end
   end

   // ==========================================
   // Context save and return next state
   // Kept apart so calls and table fetches cannot reach the save slot
   always_comb begin
      ctx_next = ctx_reg;
      rdp_next = rdp_reg;
      rdp_valid_next = 1'b0;
      rpc_next = rpc_reg;
      rpc_valid_next = 1'b0;
      if (cmd.op == OP_INT_ENTRY) begin
         ctx_next.dp = cmd.dp; // RULE_18
         ctx_next.carry = carry_reg;
         ctx_next.skip = skip_reg; // RULE_21
         ctx_next.acc = acc_reg;
         ctx_next.aux = aux_reg;
      end
      if (pop) begin
         rpc_next = stack_top; // RULE_24
         rpc_valid_next = 1'b1;
      end
      if (cmd.op == OP_INT_RETURN) begin
         rdp_next = ctx_reg.dp; // RULE_23
         rdp_valid_next = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctx_reg <= '0;
         rdp_reg <= '0;
         rpc_reg <= '0;
         rdp_valid_reg <= 1'b0;
         rpc_valid_reg <= 1'b0;
      end else if (ce) begin
         ctx_reg <= ctx_next; // RULE_19
         rdp_reg <= rdp_next;
         rpc_reg <= rpc_next;
         rdp_valid_reg <= rdp_valid_next;
         rpc_valid_reg <= rpc_valid_next;
      end
   end

   // ==========================================
   // Outputs
   always_comb begin
      view.acc = acc_reg;
      view.aux = aux_reg;
      view.carry = carry_reg;
      view.skip = skip_reg;
      view.pair = pair_reg;
      view.page_ofs = page_ofs_reg;
      view.nesting_pointer = nesting_pointer;
      view.table_addr = {page_ofs_reg, acc_reg}; // RULE_10
   end

   assign restored_dp = rdp_reg;
   assign restored_dp_valid = rdp_valid_reg;
   assign return_pc = rpc_reg;
   assign return_valid = rpc_valid_reg;
   assign skip_next = skip_reg; // RULE_20

endmodule : cpu_core_register_set

// *** regs_chk_assertions.sv ***
// Port checker for the core register set
`timescale 1ns/1ps
module regs_chk
   import core_regs_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire core_regs_pkg::cmd_t cmd,
   input wire logic [3:0] mem_data,
   input wire core_regs_pkg::view_t view,
   input wire logic [9:0] restored_dp,
   input wire logic restored_dp_valid,
   input wire logic [13:0] return_pc,
   input wire logic return_valid,
   input wire logic skip_next
);
   logic tk;
   logic [4:0] sum;
   logic [4:0] cy_acc;
   logic [7:0] ba;
   logic [6:0] da;
   logic [2:0] inc;
   logic [2:0] dec;
   // Only enabled, unreset edges take an op
   assign tk = ce && !srst;
   assign sum = view.acc + mem_data + view.carry;
   assign cy_acc = {view.carry, view.acc};
   assign ba = {view.aux, view.acc};
   assign da = {view.acc[2:0], view.acc};
   assign inc = view.nesting_pointer + 3'h1;
   assign dec = view.nesting_pointer - 3'h1;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // ==========================================
   // Checks
   amc_carry_a:
      assert property (tk && cmd.op == OP_ADD_MEM_CARRY |=> cy_acc == $past(sum)) else $error("add carry");
   add_keep_a:
      assert property (tk && cmd.op inside {OP_ADD_IMM, OP_ADD_MEM} |=> $stable(view.carry)) else $error("carry kept");
   rotate_a:
      assert property (tk && cmd.op == OP_ROTATE_RIGHT |=> {view.acc, view.carry} == $past(cy_acc)) else $error("rotate");
   set_carry_a:
      assert property (tk && cmd.op == OP_SET_CARRY |=> view.carry) else $error("set carry");
   pair_load_a:
      assert property (tk && cmd.op == OP_PAIR_FROM_AB |=> view.pair == $past(ba)) else $error("pair load");
   table_addr_a:
      assert property (tk && cmd.op == OP_LOAD_PAGE_OFS |=> view.table_addr == $past(da)) else $error("table addr");
   ptr_push_a:
      assert property (tk && cmd.op inside {OP_CALL, OP_TABLE_FETCH, OP_INT_ENTRY}
         |=> view.nesting_pointer == $past(inc)) else $error("push pointer");
   ptr_pop_a:
      assert property (tk && cmd.op == OP_RETURN |=> return_valid && view.nesting_pointer == $past(dec))
         else $error("pop pointer");
   int_ret_a:
      assert property (tk && cmd.op == OP_INT_RETURN |=> restored_dp_valid && return_valid) else $error("restore");
   cover property (tk && cmd.op == OP_INT_ENTRY);
   cover property (tk && cmd.op == OP_RETURN && view.nesting_pointer == 3'h0);
   cover property (tk && cmd.op == OP_ADD_MEM_CARRY && sum[4]);
endmodule : regs_chk

bind cpu_core_register_set regs_chk chk (.core_clk(core_clk), .srst(srst), .ce(ce), .cmd(cmd),
   .mem_data(mem_data), .view(view), .restored_dp(restored_dp), .restored_dp_valid(restored_dp_valid),
   .return_pc(return_pc), .return_valid(return_valid), .skip_next(skip_next));

// *** tb_cpu_core_register_set.sv ***
// Self-checking bench for the core register set
`timescale 1ns/1ps
module tb_cpu_core_register_set;
   import core_regs_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   cmd_t cmd = '0;
   logic [3:0] mem_data = 4'h0;
   view_t view;
   logic [9:0] restored_dp;
   logic restored_dp_valid;
   logic [13:0] return_pc;
   logic return_valid;
   logic skip_next;
   int seed = 32'ha5022b86;
   int error_cnt = 0;
   int checked = 0;
   int acc = 0, aux = 0, cy = 0, sk = 0, ptr = 7, pair = -1, pofs = -1;
   int rv, dv, rpc, s, sv, c_dp = 0, c_cy = 0, c_sk = 0, c_acc = 0, c_aux = 0;
   int stk[8];

   always #12.5 core_clk = ~core_clk;

   cpu_core_register_set dut (.core_clk(core_clk), .srst(srst), .ce(ce), .cmd(cmd), .mem_data(mem_data),
      .view(view), .restored_dp(restored_dp), .restored_dp_valid(restored_dp_valid), .return_pc(return_pc),
      .return_valid(return_valid), .skip_next(skip_next));

   task automatic cmp(input logic [15:0] got, input int want);
      checked++;
      if (got !== want[15:0]) begin
         error_cnt++;
         $display("mismatch at %0t: %h vs %h", $time, got, want[15:0]);
      end
   endtask : cmp

   // ==========================================
   // One op, then model update and compare
   task automatic run_op(input op_t o, input int n, input int pc);
      s = $random(seed);
      cmd.op = o;
      cmd.operand = n[3:0];
      cmd.bit_sel = n[5:4];
      cmd.pc = pc[13:0];
      cmd.dp = s[9:0];
      mem_data = s[13:10];
      @(posedge core_clk);
      #2;
      rv = 0;
      dv = 0;
      sv = sk;
      if (o != OP_NOP) sk = 0;
      case (o)
         OP_LOAD_ACC: acc = n & 15;
         OP_LOAD_AUX: aux = acc;
         OP_XCH_AUX: begin
            s = aux;
            aux = acc;
            acc = s;
         end
         OP_ADD_IMM: acc = (acc + n) & 15;
         OP_ADD_MEM: acc = (acc + mem_data) & 15;
         OP_ADD_MEM_CARRY: begin
            s = acc + mem_data + cy;
            acc = s & 15;
            cy = s / 16;
         end
         OP_AND_MEM: acc = acc & mem_data;
         OP_OR_MEM: acc = acc | mem_data;
         OP_CMP_MEM: sk = acc == mem_data;
         OP_BIT_SET: acc = acc | 1 << cmd.bit_sel;
         OP_BIT_CLR: acc = acc & ~(1 << cmd.bit_sel);
         OP_BIT_TEST: sk = acc >> cmd.bit_sel & 1;
         OP_ROTATE_RIGHT: begin
            s = acc & 1;
            acc = acc / 2 + cy * 8;
            cy = s;
         end
         OP_SET_CARRY: cy = 1;
         OP_RESET_CARRY: cy = 0;
         OP_PAIR_FROM_AB: pair = aux * 16 + acc;
         OP_PAIR_TO_AB: begin
            aux = pair / 16;
            acc = pair & 15;
         end
         OP_LOAD_PAGE_OFS: pofs = acc & 7;
         OP_POINTER_TO_ACC: acc = ptr;
         OP_CALL, OP_TABLE_FETCH, OP_INT_ENTRY: begin
            if (o == OP_INT_ENTRY) begin
               c_dp = s & 1023;
               c_cy = cy;
               c_sk = sv;
               c_acc = acc;
               c_aux = aux;
            end
            ptr = (ptr + 1) % 8;
            stk[ptr] = pc;
         end
         OP_RETURN, OP_INT_RETURN: begin
            rv = 1;
            rpc = stk[ptr];
            ptr = (ptr + 7) % 8;
            if (o == OP_INT_RETURN) begin
               dv = 1;
               cy = c_cy;
               sk = c_sk;
               acc = c_acc;
               aux = c_aux;
            end
         end
         OP_SKIP_SET: sk = 1;
         default: ;
      endcase
      cmp(view.acc, acc);
      cmp(view.aux, aux);
      cmp(view.carry, cy);
      cmp(view.skip, sk);
      cmp(skip_next, sk);
      cmp(view.nesting_pointer, ptr);
      cmp(return_valid, rv);
      cmp(restored_dp_valid, dv);
      if (rv) cmp(return_pc, rpc);
      if (dv) cmp(restored_dp, c_dp);
      if (pair >= 0) cmp(view.pair, pair);
      if (pofs >= 0) cmp(view.table_addr, pofs * 16 + acc);
   endtask : run_op

   task automatic end_sim;
      $display("checked %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   // Run is about 500 cycles; the limit leaves ample margin
   initial begin
      #200000;
      error_cnt++;
      end_sim();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      #2;
      srst = 1'b0;
      run_op(OP_NOP, 0, 0);
      run_op(OP_PAIR_FROM_AB, 0, 0);
      run_op(OP_LOAD_PAGE_OFS, 0, 0);
      $display("test reset done");
      for (int i = 0; i < 9; i++) run_op(i % 2 ? OP_TABLE_FETCH : OP_CALL, 0, 100 + i);
      run_op(OP_POINTER_TO_ACC, 0, 0);
      for (int i = 0; i < 9; i++) run_op(OP_RETURN, 0, 0);
      $display("test stack done");
      for (int i = 1; i < 27; i++) run_op(op_t'(i), $random(seed), 200 + i);
      $display("test codes done");
      run_op(OP_SET_CARRY, 0, 0);
      run_op(OP_SKIP_SET, 0, 0);
      run_op(OP_INT_ENTRY, 0, 300);
      run_op(OP_CALL, 0, 301);
      run_op(OP_POINTER_TO_ACC, 0, 0);
      run_op(OP_RESET_CARRY, 0, 0);
      run_op(OP_RETURN, 0, 0);
      run_op(OP_INT_RETURN, 0, 0);
      $display("test interrupt done");
      // Enable low must freeze the stack and the held return pulse
      ce = 1'b0;
      cmd.op = OP_CALL;
      @(posedge core_clk);
      #2;
      cmp(view.nesting_pointer, ptr);
      cmp(return_valid, rv);
      ce = 1'b1;
      $display("test enable done");
      repeat (400) run_op(op_t'($unsigned($random(seed)) % 27), $random(seed), 1000 + i_pc());
      $display("test random done");
      end_sim();
   end

   function automatic int i_pc();
      return $unsigned($random(seed)) % 1000;
   endfunction : i_pc
endmodule : tb_cpu_core_register_set
